// ===== core/isg_defines.svh
// Register indices, field positions, reset values and limits of the image statistics block
`ifndef ISG_DEFINES_SVH
`define ISG_DEFINES_SVH

// Register indices; the AXI byte address is four times the index
`define ISG_IDX_MEAN 6'h09
`define ISG_IDX_DARKEST 6'h0a
`define ISG_IDX_GRAB 6'h0b
`define ISG_IDX_WHEEL 6'h0c
`define ISG_IDX_CONFIG 6'h0d
`define ISG_IDX_INVREV 6'h3f

// Field positions
`define ISG_GRAB_VALID_BIT 7
`define ISG_CFG_CPI_BIT 0

// Reset values
`define ISG_RST_MEAN 8'h00
`define ISG_RST_DARKEST 8'h00
`define ISG_RST_WHEEL 8'h00
`define ISG_RST_SHUTTER 16'h0164

// Exposure loop window for the brightest pixel
`define ISG_AGC_LOW 6'h35
`define ISG_AGC_HIGH 6'h39
`define ISG_SHUTTER_MIN 16'h0001
`define ISG_SHUTTER_MAX 16'hffff

// Wheel accumulator saturation
`define ISG_WHEEL_POS_MAX 8'h7f
`define ISG_WHEEL_NEG_MAX 8'h81

// AXI responses
`define ISG_RESP_OKAY 2'h0
`define ISG_RESP_SLVERR 2'h2

`endif

// ===== core/isg_pkg.sv
// Shared types of the image statistics and pixel grabber block
package isg_pkg;

	typedef enum logic [2:0] {
		ISG_IDLE = 3'b001,
		ISG_WRESP = 3'b010,
		ISG_RDATA = 3'b100
	} isg_bus_state_t;

	typedef struct packed {
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic [1:0] prev;
		logic step_up;
		logic step_dn;
	} isg_wheel_state_t;

endpackage

// ===== core/isg_wheel_decoder.sv
// Quadrature decoder for the scroll wheel pins
`timescale 1ns/1ps
`include "isg_defines.svh"

module isg_wheel_decoder import isg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Wheel pins, asynchronous
	input wire logic wheel_a,
	input wire logic wheel_b,
	// One-cycle step pulses
	output logic step_up,
	output logic step_dn
);

	isg_wheel_state_t r, next_r;
	logic [1:0] pins;
	logic [1:0] cur;

	assign pins = {wheel_b, wheel_a};
	assign cur = r.sync_b;

	always_comb begin
		next_r = r;
		// Each pin crosses through two flops of its own; only the second stage is decoded
		next_r.sync_a = pins;
		next_r.sync_b = r.sync_a;
		next_r.prev = cur;
		next_r.step_up = 1'b0;
		next_r.step_dn = 1'b0;
		// Only single-pin changes count; a double jump is a glitch and is dropped
		if ((cur[0] ^ r.prev[0]) ^ (cur[1] ^ r.prev[1])) begin
			if (cur[1] ^ r.prev[0]) begin
				next_r.step_up = 1'b1;
			end else begin
				next_r.step_dn = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign step_up = r.step_up;
	assign step_dn = r.step_dn;

endmodule

// ===== core/isg_regs.sv
// Image statistics, pixel grabber, wheel and configuration registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "isg_defines.svh"

// Behaviour
// - darkest pixel register holds the lowest pixel of the last complete image
// - grabber captures at most one pixel from each frame
// - reading a valid grab sets MSB, advances index, rearms capture unless pixel 224 was the one read
// - any grabber write zeroes index and arms for pixel 0 of next image
// - index runs down each 15-pixel column: column times 15 plus row
// - pixel values range from 0 black to 63 white
// - exposure loop steers shutter so brightest pixel stays mid fifties
// - inverted revision register reads complement of the revision code
module isg_regs import isg_pkg::*; #(
	parameter int PIX_BITS = 6,
	parameter int ARRAY_DIM = 15,
	// Arbitrary revision value, not tied to any real part
	parameter logic [7:0] REVISION_CODE = 8'h5a
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pixel stream from the imager, same clock, column-major order
	input wire logic frame_start,
	input wire logic pix_valid,
	input wire logic [PIX_BITS-1:0] pix_value,
	// Scroll wheel pins
	input wire logic wheel_a,
	input wire logic wheel_b,
	// Control outputs
	output logic cpi_select,
	output logic [15:0] shutter_value
);

	localparam int NPIX = ARRAY_DIM * ARRAY_DIM;
	localparam int SUM_W = PIX_BITS + 8;
	localparam logic [7:0] LAST_PIX = 8'(NPIX - 1);
	localparam logic [7:0] NPIX_B = 8'(NPIX);

	// Elaboration check: the grab word needs a spare bit below the valid flag
	if (PIX_BITS < 1 || PIX_BITS > 6 || ARRAY_DIM < 2 || NPIX > 255) begin : g_bad_params
		$error("isg_regs: unsupported pixel width or array size");
	end

	typedef struct packed {
		isg_bus_state_t st;
		logic aw_got;
		logic w_got;
		logic ar_got;
		logic [5:0] aw_idx;
		logic [5:0] ar_idx;
		logic [7:0] wdata;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic rvalid;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] pix_cnt;
		logic [PIX_BITS-1:0] run_min;
		logic [PIX_BITS-1:0] run_max;
		logic [SUM_W-1:0] run_sum;
		logic [7:0] mean;
		logic [7:0] darkest;
		logic [15:0] shutter;
		logic [7:0] grab_idx;
		logic grab_valid;
		logic grab_armed;
		logic frame_taken;
		logic [PIX_BITS-1:0] grab_pix;
		logic [7:0] wheel_delta;
		logic cpi_select;
	} isg_regs_state_t;

	isg_regs_state_t r, next_r;
	logic step_up, step_dn;
	logic do_write, do_read, last_pix, cap_evt;
	logic [PIX_BITS-1:0] frame_min, frame_max;
	logic [7:0] rd_val;
	logic rd_hit;

	isg_wheel_decoder u_wheel (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.wheel_a(wheel_a),
		.wheel_b(wheel_b),
		.step_up(step_up),
		.step_dn(step_dn)
	);

	always_comb begin
		next_r = r;
		// Bus channel acceptance
		if (s_axi_awvalid && r.awready) begin
			next_r.aw_got = 1'b1;
			next_r.aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && r.wready) begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata[7:0];
		end
		if (s_axi_arvalid && r.arready) begin
			next_r.ar_got = 1'b1;
			next_r.ar_idx = s_axi_araddr[7:2];
		end
		// Reads go first when both are pending; one access at a time
		do_read = (r.st == ISG_IDLE) && r.ar_got;
		do_write = (r.st == ISG_IDLE) && !r.ar_got && r.aw_got && r.w_got;

		// Frame statistics
		last_pix = pix_valid && (r.pix_cnt == LAST_PIX);
		frame_min = (r.pix_cnt == 8'h00 || pix_value < r.run_min) ? pix_value : r.run_min;
		frame_max = (r.pix_cnt == 8'h00 || pix_value > r.run_max) ? pix_value : r.run_max;
		if (frame_start) begin
			next_r.pix_cnt = 8'h00;
		end else if (pix_valid && r.pix_cnt < NPIX_B) begin
			next_r.pix_cnt = r.pix_cnt + 8'h01;
			next_r.run_min = frame_min;
			next_r.run_max = frame_max;
			next_r.run_sum = (r.pix_cnt == 8'h00) ? SUM_W'(pix_value) : r.run_sum + SUM_W'(pix_value);
		end
		if (!frame_start && last_pix) begin
			next_r.darkest = 8'(frame_min);
			// Only the top eight bits of the image sum are kept as the mean
			next_r.mean = next_r.run_sum[SUM_W-1 -: 8];
			if (frame_max > `ISG_AGC_HIGH && r.shutter > `ISG_SHUTTER_MIN) begin
				next_r.shutter = r.shutter - 16'h0001;
			end else if (frame_max < `ISG_AGC_LOW && r.shutter != `ISG_SHUTTER_MAX) begin
				next_r.shutter = r.shutter + 16'h0001;
			end
		end

		// one capture per frame; index matches column-major count
		cap_evt = pix_valid && !frame_start && r.grab_armed && !r.frame_taken && r.pix_cnt == r.grab_idx;
		if (frame_start) begin
			next_r.frame_taken = 1'b0;
		end
		if (cap_evt) begin
			// pixel stored at its native width, black 0 up to white 63
			next_r.grab_pix = pix_value;
			next_r.grab_valid = 1'b1;
			next_r.grab_armed = 1'b0;
			next_r.frame_taken = 1'b1;
		end

		if (step_up && r.wheel_delta != `ISG_WHEEL_POS_MAX) begin
			next_r.wheel_delta = r.wheel_delta + 8'h01;
		end else if (step_dn && r.wheel_delta != `ISG_WHEEL_NEG_MAX) begin
			next_r.wheel_delta = r.wheel_delta - 8'h01;
		end

		// Read decode
		rd_hit = 1'b1;
		case (r.ar_idx)
			`ISG_IDX_MEAN: rd_val = r.mean;
			`ISG_IDX_DARKEST: rd_val = r.darkest;
			`ISG_IDX_GRAB: rd_val = {r.grab_valid, (7 - PIX_BITS)'(0), r.grab_pix};
			`ISG_IDX_WHEEL: rd_val = r.wheel_delta;
			`ISG_IDX_CONFIG: rd_val = {7'h00, r.cpi_select};
			`ISG_IDX_INVREV: rd_val = ~REVISION_CODE;
			default: begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase

		if (do_read) begin
			next_r.ar_got = 1'b0;
			next_r.st = ISG_RDATA;
			next_r.rvalid = 1'b1;
			next_r.rdata = {24'h000000, rd_val};
			next_r.rresp = rd_hit ? `ISG_RESP_OKAY : `ISG_RESP_SLVERR;
			// valid grab read advances, and rearms unless the last pixel was read
			if (r.ar_idx == `ISG_IDX_GRAB && r.grab_valid) begin
				next_r.grab_valid = 1'b0;
				next_r.grab_idx = r.grab_idx + 8'h01;
				next_r.grab_armed = (r.grab_idx + 8'h01) < NPIX_B;
			end
			// Wheel count clears on read; a step in the same cycle survives
			if (r.ar_idx == `ISG_IDX_WHEEL) begin
				next_r.wheel_delta = step_up ? 8'h01 : (step_dn ? 8'hff : 8'h00);
			end
		end
		if (do_write) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.st = ISG_WRESP;
			next_r.bvalid = 1'b1;
			next_r.bresp = `ISG_RESP_OKAY;
			case (r.aw_idx)
				`ISG_IDX_GRAB: begin
					// restart at pixel 0 on the next image, not the current one
					next_r.grab_idx = 8'h00;
					next_r.grab_valid = 1'b0;
					next_r.grab_armed = 1'b1;
					next_r.frame_taken = !frame_start;
				end
				`ISG_IDX_CONFIG: begin
					// only the resolution bit is stored
					next_r.cpi_select = r.wdata[`ISG_CFG_CPI_BIT];
				end
				`ISG_IDX_MEAN, `ISG_IDX_DARKEST, `ISG_IDX_WHEEL, `ISG_IDX_INVREV: begin
					next_r.bresp = `ISG_RESP_OKAY;
				end
				default: begin
					next_r.bresp = `ISG_RESP_SLVERR;
				end
			endcase
		end
		if (r.st == ISG_RDATA && s_axi_rready) begin
			next_r.rvalid = 1'b0;
			next_r.st = ISG_IDLE;
		end
		if (r.st == ISG_WRESP && s_axi_bready) begin
			next_r.bvalid = 1'b0;
			next_r.st = ISG_IDLE;
		end
		// Readies registered so they come straight from flops
		next_r.awready = !next_r.aw_got;
		next_r.wready = !next_r.w_got;
		next_r.arready = !next_r.ar_got;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ISG_IDLE;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.mean <= `ISG_RST_MEAN;
			r.darkest <= `ISG_RST_DARKEST;
			r.wheel_delta <= `ISG_RST_WHEEL;
			r.shutter <= `ISG_RST_SHUTTER;
			r.pix_cnt <= NPIX_B;
			r.grab_armed <= 1'b1;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_arready = r.arready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign cpi_select = r.cpi_select;
	assign shutter_value = r.shutter;

	// Helper: captures seen since the last frame start
	logic [1:0] caps_in_frame;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			caps_in_frame <= 2'h0;
		end else if (ce) begin
			if (frame_start) begin
				caps_in_frame <= 2'h0;
			end else if (cap_evt && caps_in_frame != 2'h3) begin
				caps_in_frame <= caps_in_frame + 2'h1;
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	chk_min_latch: assert property (ce && last_pix && !frame_start |=> r.darkest == 8'($past(frame_min)))
		else $error("darkest pixel not latched at image end");
	chk_one_per_frame: assert property (caps_in_frame <= 2'h1)
		else $error("more than one pixel grabbed in a frame");
	chk_grab_read: assert property (ce && do_read && r.ar_idx == `ISG_IDX_GRAB && r.grab_valid
		|=> s_axi_rvalid && s_axi_rdata[`ISG_GRAB_VALID_BIT] && r.grab_idx == $past(r.grab_idx) + 8'h01)
		else $error("valid grab read did not flag or advance");
	chk_write_rearm: assert property (ce && do_write && r.aw_idx == `ISG_IDX_GRAB
		|=> r.grab_idx == 8'h00 && r.grab_armed && !r.grab_valid)
		else $error("grabber write did not restart at pixel 0");
	chk_index_order: assert property (cap_evt |-> r.pix_cnt == r.grab_idx && r.grab_idx <= LAST_PIX)
		else $error("capture at wrong pixel index");
	chk_pixel_range: assert property (s_axi_rvalid && $rose(s_axi_rvalid) && $past(r.ar_idx) == `ISG_IDX_GRAB
		|-> s_axi_rdata[31:PIX_BITS+1] == '0 || s_axi_rdata[31:8] == '0 && s_axi_rdata[6:PIX_BITS] == '0)
		else $error("grabbed value out of range");
	chk_agc_step: assert property (ce && last_pix && !frame_start && frame_max > `ISG_AGC_HIGH
		&& r.shutter > `ISG_SHUTTER_MIN |=> shutter_value == $past(shutter_value) - 16'h0001)
		else $error("shutter did not shorten on bright image");
	chk_inv_rev: assert property (ce && do_read && r.ar_idx == `ISG_IDX_INVREV
		|=> s_axi_rdata == {24'h000000, ~REVISION_CODE} && s_axi_rresp == `ISG_RESP_OKAY)
		else $error("inverted revision mismatch");
	chk_wheel_clear: assert property (ce && do_read && r.ar_idx == `ISG_IDX_WHEEL && !step_up && !step_dn
		|=> s_axi_rdata[7:0] == $past(r.wheel_delta) && r.wheel_delta == 8'h00)
		else $error("wheel delta not returned and cleared");
	chk_cpi_follow: assert property (ce && do_write && r.aw_idx == `ISG_IDX_CONFIG
		|=> cpi_select == $past(r.wdata[`ISG_CFG_CPI_BIT]) ##1 s_axi_bresp == `ISG_RESP_OKAY [*1])
		else $error("resolution select not written");

	cov_grab_read: cover property (do_read && r.ar_idx == `ISG_IDX_GRAB && r.grab_valid);
	cov_grab_write: cover property (do_write && r.aw_idx == `ISG_IDX_GRAB);
	cov_frame_end: cover property (last_pix && cap_evt);
	cov_wheel_read: cover property (do_read && r.ar_idx == `ISG_IDX_WHEEL && r.wheel_delta != 8'h00);

endmodule

// ===== bench/isg_regs_tb.sv
// Self-checking bench for the image statistics and pixel grabber register block
`timescale 1ns/1ps
`include "isg_defines.svh"
`define TB_CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
	end \
end

module isg_regs_tb import isg_pkg::*; ;
	// Arbitrary revision value, not tied to any real part
	localparam logic [7:0] REV = 8'h3c;
	logic clock = 1'b0;
	logic rst_n, ce, awvalid, wvalid, bready, arvalid, rready, frame_start, pix_valid, wheel_a, wheel_b;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [5:0] pix_value, last;
	logic awready, wready, bvalid, arready, rvalid, cpi_select, up;
	logic [1:0] bresp, rresp, r, ph;
	logic [15:0] shutter_value;
	logic [31:0] seed = 32'h93988d21;
	int fails = 0;
	int total_checks = 0;
	int img[225];
	int dark_exp = 0;
	int mean_exp = 0;
	int sh = 32'h164;

	always #20 clock = ~clock;

	isg_regs #(.REVISION_CODE(REV)) dut_u (
		.clock(clock), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.frame_start(frame_start), .pix_valid(pix_valid), .pix_value(pix_value),
		.wheel_a(wheel_a), .wheel_b(wheel_b), .cpi_select(cpi_select), .shutter_value(shutter_value)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] idx, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'(rnd());
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		if (n >= 100) fails++;
		`TB_CHK(bresp, er)
	endtask

	task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n >= 100) fails++;
	endtask

	task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
		rd(idx, d, r);
		`TB_CHK(d, {24'h0, e})
		`TB_CHK(r, `ISG_RESP_OKAY)
	endtask

	// Model keeps min, sum and max; only a complete image moves the statistics
	task automatic frame(input int n, input logic [5:0] m);
		int v, mn, mx, sum;
		mn = 63;
		mx = 0;
		sum = 0;
		@(posedge clock);
		frame_start <= 1'b1;
		@(posedge clock);
		frame_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			v = rnd() & m;
			img[i] = v;
			pix_valid <= 1'b1;
			pix_value <= v[5:0];
			mn = v < mn ? v : mn;
			mx = v > mx ? v : mx;
			sum += v;
			@(posedge clock);
		end
		pix_valid <= 1'b0;
		if (n == 225) begin
			dark_exp = mn;
			mean_exp = sum >> 6;
			if (mx > 57 && sh > 1) sh--;
			else if (mx < 53 && sh < 65535) sh++;
		end
	endtask

	task automatic stats();
		rdchk(`ISG_IDX_DARKEST, dark_exp[7:0]);
		rdchk(`ISG_IDX_MEAN, mean_exp[7:0]);
		`TB_CHK(shutter_value, sh[15:0])
	endtask

	// Gray-code steps on the wheel pins, spaced past the synchroniser delay
	task automatic turn(input int n, input logic fwd);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			ph = fwd ? ph + 2'd1 : ph - 2'd1;
			wheel_a <= ph[1];
			wheel_b <= ph[1] ^ ph[0];
			repeat (7) @(posedge clock);
		end
	endtask

	initial begin
		repeat (90000) @(posedge clock);
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, frame_start, pix_valid, wheel_a, wheel_b} = '0;
		{awaddr, araddr, wdata, wstrb, pix_value} = '0;
		ph = 2'd0;
		repeat (20) @(posedge clock);
		`TB_CHK(shutter_value, `ISG_RST_SHUTTER)
		`TB_CHK(cpi_select, 1'b0)
		rst_n <= 1'b1;
		foreach (img[i]) img[i] = 0;
		for (int k = 9; k <= 13; k++) rdchk(k[5:0], 8'h00);
		rdchk(`ISG_IDX_INVREV, ~REV);
		rd(6'h20, d, r);
		`TB_CHK(r, `ISG_RESP_SLVERR)
		`TB_CHK(d, 32'h0)
		wr(6'h20, rnd(), `ISG_RESP_SLVERR);
		wr(`ISG_IDX_CONFIG, 32'h1, `ISG_RESP_OKAY);
		`TB_CHK(cpi_select, 1'b1)
		rdchk(`ISG_IDX_CONFIG, 8'h01);
		wr(`ISG_IDX_CONFIG, 32'hfe, `ISG_RESP_OKAY);
		`TB_CHK(cpi_select, 1'b0)
		wr(`ISG_IDX_MEAN, 32'hff, `ISG_RESP_OKAY);
		rdchk(`ISG_IDX_MEAN, 8'h00);
		frame(225, 6'h3f);
		stats();
		// A frame cut short must leave the statistics alone
		frame(100, 6'h00);
		stats();
		wr(`ISG_IDX_GRAB, rnd(), `ISG_RESP_OKAY);
		for (int f = 0; f < 225; f++) begin
			frame(225, f[0] ? 6'h1f : 6'h3f);
			rdchk(`ISG_IDX_GRAB, {2'b10, img[f][5:0]});
			`TB_CHK(shutter_value, sh[15:0])
			if (f % 32 == 0) rdchk(`ISG_IDX_GRAB, {2'b00, img[f][5:0]});
			if (f % 16 == 0) stats();
		end
		last = img[224][5:0];
		frame(225, 6'h3f);
		rdchk(`ISG_IDX_GRAB, {2'b00, last});
		wr(`ISG_IDX_GRAB, rnd(), `ISG_RESP_OKAY);
		frame(225, 6'h3f);
		rdchk(`ISG_IDX_GRAB, {2'b10, img[0][5:0]});
		// Step direction of the decoder is left open, so the first read fixes the sign
		turn(6, 1'b1);
		rd(`ISG_IDX_WHEEL, d, r);
		`TB_CHK(d === 32'h6 || d === 32'hfa, 1'b1)
		up = d === 32'h6;
		turn(6, 1'b0);
		rdchk(`ISG_IDX_WHEEL, up ? 8'hfa : 8'h06);
		turn(200, 1'b1);
		rdchk(`ISG_IDX_WHEEL, up ? `ISG_WHEEL_POS_MAX : `ISG_WHEEL_NEG_MAX);
		rdchk(`ISG_IDX_WHEEL, 8'h00);
		// Pin activity while frozen must leave no trace once the clock enable returns
		ce <= 1'b0;
		turn(4, 1'b1);
		ce <= 1'b1;
		rdchk(`ISG_IDX_WHEEL, 8'h00);
		complete_run();
	end
endmodule
